/* File: rtl/dras_device.sv */
// Device end: command interpreter owning the frame memory and settings.
// Assumes host keeps its own ordering duties; bytes enter via a FIFO.
//
// Summary of operation
// [RULE_01] Fill option bit 4 enables reverse copy
// [RULE_02] First scroll parameter is horizontal offset
// [RULE_03] Host keeps start row plus count <=132
// [RULE_04] Fourth scroll parameter is vertical offset
// [RULE_05] Interval code picks 3/5/50/100 frames
// [RULE_06] Host leaves scroll setup alone while active
// [RULE_07] 2Eh stops scrolling; host rewrites memory
// [RULE_08] 2Fh starts scrolling with last setup
// [RULE_09] A3h loads fixed rows and scroll rows
// [RULE_10] Host keeps scroll area within multiplex
// [RULE_11] Vertical scroll wraps last row to first
// [RULE_12] 15h loads column window, pointer to start
// [RULE_13] After 5Ch data bytes write memory
// [RULE_14] After 5Dh data bytes read memory
// [RULE_15] 75h loads row window, pointer to start
// [RULE_16] Horizontal mode: column first, then row
// [RULE_17] Vertical mode: row first, then column
// [RULE_18] Three contrast commands, one per colour
// [RULE_19] 87h sets master scale, reset sixteen; code resets to 0Fh (fifteen)
// [RULE_20] Remap bit 1 mirrors segment columns
// [RULE_21] Remap bits 2-4: colour, sides, scan
// [RULE_22] Remap bit 5 split; bits 7:6 format
`timescale 1ns/1ps
`default_nettype none
module dras_device
   import dras_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   // Link to host
   dras_link_if.dev link,
   // Settings seen by the panel drive
   output logic [7:0] contrast_a_out,
   output logic [7:0] contrast_b_out,
   output logic [7:0] contrast_c_out,
   output logic [3:0] master_scale_out,
   output logic col_mirror_out,
   output logic rgb_swap_out,
   output logic common_lr_swap_out,
   output logic common_scan_rev_out,
   output logic common_split_out,
   output logic [1:0] color_fmt_out,
   output logic reverse_copy_out,
   output logic scroll_active_out,
   output logic [7:0] hscroll_pos_out,
   output logic [7:0] vscroll_pos_out,
   output logic [7:0] vfix_rows_out,
   output logic [7:0] vscroll_rows_out
);
   typedef enum logic [1:0] {DRAS_IDLE, DRAS_PARAM, DRAS_WRITE, DRAS_READ}
      dras_mode_e;

   typedef struct packed {
      dras_mode_e mode;
      logic [7:0] cmd;
      logic [2:0] pidx;
      logic [7:0] col_start, col_end, col_ptr;
      logic [7:0] row_start, row_end, row_ptr;
      logic [7:0] con_a, con_b, con_c;
      logic [3:0] master;
      logic [7:0] remap;
      logic [7:0] fillopt;
      logic [7:0] h_off, s_row, s_cnt, v_off;
      logic [1:0] interval;
      logic [7:0] vfix, vscr;
      logic active;
      logic [15:0] fcnt;
      logic [7:0] frames;
      logic [7:0] hpos, vpos;
      logic rd_valid;
      logic [7:0] rd_data;
   } dras_state_s;

   logic [7:0] fmem [DRAS_COLS*DRAS_ROWS];
   dras_state_s s_reg;
   dras_state_s s_next;
   logic f_valid;
   logic f_ready;
   logic [8:0] f_data;
   logic mem_we;
   logic [14:0] mem_addr;

   // FIFO lets the host burst while a read is being answered
   dras_fifo #(.WIDTH(9), .DEPTH(DRAS_FIFO_DEPTH)) u_fifo (
      .clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in),
      .in_valid_in(link.valid),
      .in_ready_out(link.ready),
      .in_data_in({link.dc_sel, link.data}),
      .out_valid_out(f_valid),
      .out_ready_in(f_ready),
      .out_data_out(f_data)
   );

   function automatic logic [7:0] dras_frames(input logic [1:0] code);
      case (code)
         2'b00: dras_frames = DRAS_FRAMES_0; // RULE_05
         2'b01: dras_frames = DRAS_FRAMES_1;
         2'b10: dras_frames = DRAS_FRAMES_2;
         default: dras_frames = DRAS_FRAMES_3;
      endcase
   endfunction : dras_frames

   function automatic logic [7:0] dras_wrap(input logic [7:0] pos,
      input logic [7:0] step, input logic [7:0] span);
      logic [8:0] sum;
      sum = {1'b0, pos} + {1'b0, step};
      if (span == 8'h00) begin
         dras_wrap = 8'h00;
      end else if (sum >= {1'b0, span}) begin
         dras_wrap = 8'(sum - {1'b0, span});
      end else begin
         dras_wrap = sum[7:0];
      end
   endfunction : dras_wrap

   // Reads take a byte only when the answer slot is free
   assign f_ready = !(s_reg.mode == DRAS_READ && f_data[8] && s_reg.rd_valid);
   assign mem_addr = 15'(s_reg.row_ptr) * 15'(DRAS_COLS) + 15'(s_reg.col_ptr);
   assign mem_we = f_valid && f_ready && f_data[8] &&
      s_reg.mode == DRAS_WRITE; // RULE_13

   always_ff @(posedge clk_sys_in) begin
      if (mem_we) begin
         fmem[mem_addr] <= f_data[7:0];
      end
   end

   always_comb begin
      logic take;
      logic acc;
      logic is_dat;
      logic [7:0] b;
      take = f_valid && f_ready;
      is_dat = f_data[8];
      b = f_data[7:0];
      s_next = s_reg;
      acc = 1'b0;
      s_next.rd_valid = 1'b0;
      if (take && !is_dat) begin
         // Any command ends a memory session
         s_next.cmd = b;
         s_next.pidx = '0;
         s_next.mode = DRAS_PARAM;
         case (b)
            DRAS_CMD_WRITE: s_next.mode = DRAS_WRITE; // RULE_13
            DRAS_CMD_READ: s_next.mode = DRAS_READ; // RULE_14
            DRAS_CMD_STOP: begin
               s_next.active = 1'b0; // RULE_07
               s_next.mode = DRAS_IDLE;
            end
            DRAS_CMD_START: begin
               s_next.active = 1'b1; // RULE_08
               s_next.fcnt = '0;
               s_next.frames = '0;
               s_next.mode = DRAS_IDLE;
            end
            default: ;
         endcase
      end else if (take && is_dat) begin
         case (s_reg.mode)
            DRAS_WRITE: acc = 1'b1;
            DRAS_READ: begin
               acc = 1'b1; // RULE_14
               s_next.rd_valid = 1'b1;
               s_next.rd_data = fmem[mem_addr];
            end
            DRAS_PARAM: begin
               s_next.pidx = s_reg.pidx + 3'd1;
               case (s_reg.cmd)
                  DRAS_CMD_COL: begin
                     if (s_reg.pidx == 3'd0) begin
                        s_next.col_start = b; // RULE_12
                        s_next.col_ptr = b;
                     end else begin
                        s_next.col_end = b;
                     end
                  end
                  DRAS_CMD_ROW: begin
                     if (s_reg.pidx == 3'd0) begin
                        s_next.row_start = b; // RULE_15
                        s_next.row_ptr = b;
                     end else begin
                        s_next.row_end = b;
                     end
                  end
                  DRAS_CMD_CON_A: s_next.con_a = b; // RULE_18
                  DRAS_CMD_CON_B: s_next.con_b = b;
                  DRAS_CMD_CON_C: s_next.con_c = b;
                  DRAS_CMD_MASTER: s_next.master = b[3:0]; // RULE_19
                  DRAS_CMD_REMAP: s_next.remap = b; // RULE_20
                  DRAS_CMD_FILLOPT: s_next.fillopt = b; // RULE_01
                  DRAS_CMD_VAREA: begin
                     if (s_reg.pidx == 3'd0) begin
                        s_next.vfix = b; // RULE_09
                     end else begin
                        s_next.vscr = b;
                     end
                  end
                  DRAS_CMD_SCROLL: begin
                     case (s_reg.pidx)
                        3'd0: s_next.h_off = b; // RULE_02
                        3'd1: s_next.s_row = b;
                        3'd2: s_next.s_cnt = b;
                        3'd3: s_next.v_off = b; // RULE_04
                        default: s_next.interval = b[1:0]; // RULE_05
                     endcase
                  end
                  default: ;
               endcase
            end
            default: ;
         endcase
      end
      // Pointer advance after each memory access
      if (acc) begin
         if (!s_reg.remap[DRAS_REMAP_INC_BIT]) begin
            if (s_reg.col_ptr == s_reg.col_end) begin
               s_next.col_ptr = s_reg.col_start; // RULE_16
               s_next.row_ptr = (s_reg.row_ptr == s_reg.row_end) ?
                  s_reg.row_start : s_reg.row_ptr + 8'd1;
            end else begin
               s_next.col_ptr = s_reg.col_ptr + 8'd1;
            end
         end else begin
            if (s_reg.row_ptr == s_reg.row_end) begin
               s_next.row_ptr = s_reg.row_start; // RULE_17
               s_next.col_ptr = (s_reg.col_ptr == s_reg.col_end) ?
                  s_reg.col_start : s_reg.col_ptr + 8'd1;
            end else begin
               s_next.row_ptr = s_reg.row_ptr + 8'd1;
            end
         end
      end
      // Frame tick is a stand-in for the panel frame rate
      if (s_reg.active) begin
         if (s_reg.fcnt == DRAS_FRAME_CYCLES - 16'd1) begin
            s_next.fcnt = '0;
            if (s_reg.frames == dras_frames(s_reg.interval) - 8'd1) begin
               s_next.frames = '0;
               s_next.hpos = dras_wrap(s_reg.hpos, s_reg.h_off,
                  DRAS_COL_MAX + 8'd1);
               // Last scroll row wraps to first row of the area
               s_next.vpos = dras_wrap(s_reg.vpos, s_reg.v_off,
                  s_reg.vscr); // RULE_11
            end else begin
               s_next.frames = s_reg.frames + 8'd1;
            end
         end else begin
            s_next.fcnt = s_reg.fcnt + 16'd1;
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s_reg <= '0;
         s_reg.mode <= DRAS_IDLE;
         s_reg.col_end <= DRAS_RST_COL_END;
         s_reg.row_end <= DRAS_RST_ROW_END;
         s_reg.con_a <= DRAS_RST_CONTRAST;
         s_reg.con_b <= DRAS_RST_CONTRAST;
         s_reg.con_c <= DRAS_RST_CONTRAST;
         s_reg.master <= DRAS_RST_MASTER;
         s_reg.remap <= DRAS_RST_REMAP;
         s_reg.vfix <= DRAS_RST_VFIX;
         s_reg.vscr <= DRAS_RST_VSCR;
      end else begin
         s_reg <= s_next;
      end
   end

   assign link.rd_valid = s_reg.rd_valid;
   assign link.rd_data = s_reg.rd_data;
   assign contrast_a_out = s_reg.con_a;
   assign contrast_b_out = s_reg.con_b;
   assign contrast_c_out = s_reg.con_c;
   assign master_scale_out = s_reg.master;
   assign col_mirror_out = s_reg.remap[DRAS_REMAP_COL_BIT]; // RULE_20
   assign rgb_swap_out = s_reg.remap[DRAS_REMAP_RGB_BIT]; // RULE_21
   assign common_lr_swap_out = s_reg.remap[DRAS_REMAP_LR_BIT];
   assign common_scan_rev_out = s_reg.remap[DRAS_REMAP_SCAN_BIT];
   assign common_split_out = s_reg.remap[DRAS_REMAP_SPLIT_BIT]; // RULE_22
   assign color_fmt_out = s_reg.remap[7:6];
   assign reverse_copy_out = s_reg.fillopt[DRAS_FILL_REV_BIT]; // RULE_01
   assign scroll_active_out = s_reg.active;
   assign hscroll_pos_out = s_reg.hpos;
   assign vscroll_pos_out = s_reg.vpos;
   assign vfix_rows_out = s_reg.vfix;
   assign vscroll_rows_out = s_reg.vscr;
endmodule : dras_device
`default_nettype wire

/* File: rtl/dras_pkg.sv */
// Package: command codes, reset values and sizes for the frame memory
// command interpreter. Shared by the device end and the host end.
package dras_pkg;
   localparam int DRAS_COLS = 160;
   localparam int DRAS_ROWS = 132;
   localparam int DRAS_FIFO_DEPTH = 4;
   localparam logic [7:0] DRAS_CMD_COL = 8'h15;
   localparam logic [7:0] DRAS_CMD_WRITE = 8'h5C;
   localparam logic [7:0] DRAS_CMD_READ = 8'h5D;
   localparam logic [7:0] DRAS_CMD_ROW = 8'h75;
   localparam logic [7:0] DRAS_CMD_CON_A = 8'h81;
   localparam logic [7:0] DRAS_CMD_CON_B = 8'h82;
   localparam logic [7:0] DRAS_CMD_CON_C = 8'h83;
   localparam logic [7:0] DRAS_CMD_MASTER = 8'h87;
   localparam logic [7:0] DRAS_CMD_REMAP = 8'hA0;
   localparam logic [7:0] DRAS_CMD_VAREA = 8'hA3;
   localparam logic [7:0] DRAS_CMD_FILLOPT = 8'h26;
   localparam logic [7:0] DRAS_CMD_SCROLL = 8'h27;
   localparam logic [7:0] DRAS_CMD_STOP = 8'h2E;
   localparam logic [7:0] DRAS_CMD_START = 8'h2F;
   localparam logic [7:0] DRAS_RST_COL_END = 8'h9F;
   localparam logic [7:0] DRAS_RST_ROW_END = 8'h83;
   localparam logic [7:0] DRAS_RST_CONTRAST = 8'h80;
   localparam logic [3:0] DRAS_RST_MASTER = 4'hF;
   localparam logic [7:0] DRAS_RST_REMAP = 8'h00;
   localparam logic [7:0] DRAS_RST_VFIX = 8'h00;
   localparam logic [7:0] DRAS_RST_VSCR = 8'h84;
   localparam logic [7:0] DRAS_MAX_OFFSET = 8'h83;
   localparam logic [7:0] DRAS_COL_MAX = 8'h9F;
   localparam int DRAS_FILL_REV_BIT = 4;
   localparam int DRAS_REMAP_INC_BIT = 0;
   localparam int DRAS_REMAP_COL_BIT = 1;
   localparam int DRAS_REMAP_RGB_BIT = 2;
   localparam int DRAS_REMAP_LR_BIT = 3;
   localparam int DRAS_REMAP_SCAN_BIT = 4;
   localparam int DRAS_REMAP_SPLIT_BIT = 5;
   localparam logic [7:0] DRAS_FRAMES_0 = 8'h03;
   localparam logic [7:0] DRAS_FRAMES_1 = 8'h05;
   localparam logic [7:0] DRAS_FRAMES_2 = 8'h32;
   localparam logic [7:0] DRAS_FRAMES_3 = 8'h64;
   localparam logic [15:0] DRAS_FRAME_CYCLES = 16'h0040;
endpackage : dras_pkg

/* File: rtl/dras_link_if.sv */
// Interface: byte link between host and device, dc_sel high for data.
// Assumes one shared clock; read bytes return on rd_valid/rd_data.
`timescale 1ns/1ps
`default_nettype none
interface dras_link_if;
   logic valid;
   logic ready;
   logic dc_sel;
   logic rd_req;
   logic [7:0] data;
   logic rd_valid;
   logic [7:0] rd_data;
   modport host (output valid, output dc_sel, output rd_req,
      output data, input ready, input rd_valid, input rd_data);
   modport dev (input valid, input dc_sel, input rd_req, input data,
      output ready, output rd_valid, output rd_data);
endinterface : dras_link_if
`default_nettype wire

/* File: rtl/dras_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module dras_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   // Fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   // Drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_reg;
   logic [AW-1:0] rp_reg;
   logic [AW:0] cnt_reg;
   logic push;
   logic pop;
   assign in_ready_out = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid_out = (cnt_reg != '0);
   assign out_data_out = mem[rp_reg];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   always_ff @(posedge clk_sys_in) begin
      if (push) begin
         mem[wp_reg] <= in_data_in;
      end
   end
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
         end
         if (pop) begin
            rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
         end
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : dras_fifo
`default_nettype wire

/* File: rtl/dras_host.sv */
// Host end: turns user requests into command and data bytes on the link.
// Assumes user holds a request until it is accepted.
`timescale 1ns/1ps
`default_nettype none
module dras_host
   import dras_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   // User request
   input wire logic req_valid_in,
   input wire logic req_dc_in,
   input wire logic req_rd_in,
   input wire logic [7:0] req_data_in,
   output logic req_ready_out,
   // User read answer
   output logic ans_valid_out,
   output logic [7:0] ans_data_out,
   // Link to device
   dras_link_if.host link
);
   typedef struct packed {
      logic valid;
      logic dc;
      logic rd;
      logic [7:0] data;
      logic active;
      logic ans_valid;
      logic [7:0] ans_data;
   } dras_hstate_s;

   dras_hstate_s h_reg;
   dras_hstate_s h_next;

   always_comb begin
      logic sent;
      sent = h_reg.valid && link.ready;
      h_next = h_reg;
      h_next.ans_valid = link.rd_valid;
      h_next.ans_data = link.rd_valid ? link.rd_data : h_reg.ans_data;
      if (sent) begin
         h_next.valid = 1'b0;
         if (!h_reg.dc && h_reg.data == DRAS_CMD_START) begin
            h_next.active = 1'b1;
         end else if (!h_reg.dc && h_reg.data == DRAS_CMD_STOP) begin
            h_next.active = 1'b0; // RULE_07
         end
      end
      if (req_valid_in && req_ready_out) begin
         h_next.valid = 1'b1;
         h_next.dc = req_dc_in;
         h_next.rd = req_rd_in;
         h_next.data = req_data_in;
      end
   end

   // Scroll setup withheld while scrolling runs; RULE_06
   assign req_ready_out = !h_reg.valid &&
      !(h_reg.active && !req_dc_in && req_data_in == DRAS_CMD_SCROLL);

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         h_reg <= '0;
      end else begin
         h_reg <= h_next;
      end
   end

   assign link.valid = h_reg.valid;
   assign link.dc_sel = h_reg.dc;
   assign link.rd_req = h_reg.rd;
   assign link.data = h_reg.data;
   assign ans_valid_out = h_reg.ans_valid;
   assign ans_data_out = h_reg.ans_data;
endmodule : dras_host
`default_nettype wire

/* File: tb/dras_link_asserts.sv */
// Checker: handshake and read answer timing on the host-device link.
// Assumes one clock; sits beside the link interface in the testbench.
`timescale 1ns/1ps
`default_nettype none
module dras_link_asserts
   import dras_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   // Host to device
   input wire logic valid,
   input wire logic dc_sel,
   input wire logic rd_req,
   input wire logic [7:0] data,
   // Device to host
   input wire logic ready,
   input wire logic rd_valid,
   input wire logic [7:0] rd_data
);
   logic rd_mode_reg;
   logic [3:0] pend_reg;
   logic take;
   assign take = valid && ready;
   // Reads still owed an answer; FIFO depth keeps this small
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rd_mode_reg <= 1'b0;
         pend_reg <= 4'h0;
      end else begin
         if (take && !dc_sel) begin
            rd_mode_reg <= (data == DRAS_CMD_READ);
         end
         pend_reg <= pend_reg + 4'(take && dc_sel && rd_mode_reg) -
            4'(rd_valid);
      end
   end
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!resetn_in);
   req_hold_a: assert property (valid && !ready |=> valid)
      else $error("link request dropped before acceptance");
   data_hold_a: assert property (valid && !ready |=> $stable(data))
      else $error("link byte changed while waiting");
   dc_hold_a: assert property (valid && !ready |=> $stable(dc_sel))
      else $error("link select changed while waiting");
   rdv_pulse_a: assert property (rd_valid |=> !rd_valid)
      else $error("read answer longer than one cycle");
   rd_cause_a: assert property (rd_valid |-> pend_reg != 4'h0)
      else $error("read answer without a read request");
   rd_answer_a: assert property (
      take && dc_sel && rd_mode_reg |-> ##[2:24] rd_valid)
      else $error("read request not answered in time");
   reset_idle_a: assert property ($rose(resetn_in) |-> !valid)
      else $error("link busy straight after reset");
   ready_back_a: assert property (!ready |-> ##[1:40] ready)
      else $error("link refused for too long");
endmodule : dras_link_asserts
`default_nettype wire

/* File: tb/display_ram_addressing_scroll_tb.sv */
// Testbench: host end and device end joined by the link interface.
// Assumes the package constants; drives the host's user side only.
`timescale 1ns/1ps
`default_nettype none
module display_ram_addressing_scroll_tb;
   import dras_pkg::*;
   logic clk_sys_in = 1'b0;
   logic resetn_in = 1'b0;
   logic req_valid_in = 1'b0;
   logic req_dc_in = 1'b0;
   logic req_rd_in = 1'b0;
   logic [7:0] req_data_in = 8'h00;
   logic req_ready_out, ans_valid_out, scroll_active_out, reverse_copy_out;
   logic col_mirror_out, rgb_swap_out, common_lr_swap_out;
   logic common_scan_rev_out, common_split_out;
   logic [1:0] color_fmt_out;
   logic [3:0] master_scale_out;
   logic [7:0] ans_data_out, contrast_a_out, contrast_b_out, contrast_c_out;
   logic [7:0] hscroll_pos_out, vscroll_pos_out, vfix_rows_out;
   logic [7:0] vscroll_rows_out, h0, v0;
   logic [7:0] ansq[$];
   logic [7:0] expq[$];
   logic [7:0] mem[int];
   int fails = 0;
   int comparisons = 0;
   int cs, ce, rs, re, cp, rp, gap;
   bit vert = 1'b0;
   int frames[4] = '{3, 5, 50, 100};
   int hoffs[4] = '{0, 1, 131, 7};
   dras_link_if dras_link_if_inst ();
   dras_host dras_host_inst (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
      .req_valid_in(req_valid_in), .req_dc_in(req_dc_in),
      .req_rd_in(req_rd_in), .req_data_in(req_data_in),
      .req_ready_out(req_ready_out), .ans_valid_out(ans_valid_out),
      .ans_data_out(ans_data_out), .link(dras_link_if_inst));
   dras_device dras_device_inst (.clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in), .link(dras_link_if_inst),
      .contrast_a_out(contrast_a_out), .contrast_b_out(contrast_b_out),
      .contrast_c_out(contrast_c_out), .master_scale_out(master_scale_out),
      .col_mirror_out(col_mirror_out), .rgb_swap_out(rgb_swap_out),
      .common_lr_swap_out(common_lr_swap_out),
      .common_scan_rev_out(common_scan_rev_out),
      .common_split_out(common_split_out), .color_fmt_out(color_fmt_out),
      .reverse_copy_out(reverse_copy_out),
      .scroll_active_out(scroll_active_out),
      .hscroll_pos_out(hscroll_pos_out), .vscroll_pos_out(vscroll_pos_out),
      .vfix_rows_out(vfix_rows_out), .vscroll_rows_out(vscroll_rows_out));
   dras_link_asserts dras_link_asserts_inst (.clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in), .valid(dras_link_if_inst.valid),
      .dc_sel(dras_link_if_inst.dc_sel), .rd_req(dras_link_if_inst.rd_req),
      .data(dras_link_if_inst.data), .ready(dras_link_if_inst.ready),
      .rd_valid(dras_link_if_inst.rd_valid),
      .rd_data(dras_link_if_inst.rd_data));
   always #2.5 clk_sys_in = ~clk_sys_in;
   // Answers are registered; the falling edge sees them settled
   always @(negedge clk_sys_in) begin
      if (ans_valid_out === 1'b1) begin
         ansq.push_back(ans_data_out);
      end
   end
   task automatic report_and_stop();
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
   endtask : chk8
   task automatic chkn(input int got, input int exp);
      comparisons++;
      if (got != exp) begin
         fails++;
         $display("CHECK FAILED %0t count %0d want %0d", $time, got, exp);
      end
   endtask : chkn
   // Holds the byte until accepted, then one idle edge before the next
   task automatic put(input logic dc, input logic rd, input logic [7:0] b);
      req_valid_in <= 1'b1;
      req_dc_in <= dc;
      req_rd_in <= rd;
      req_data_in <= b;
      do @(negedge clk_sys_in); while (req_ready_out !== 1'b1);
      @(posedge clk_sys_in);
      req_valid_in <= 1'b0;
      @(posedge clk_sys_in);
   endtask : put
   // Parameters packed first byte lowest; settings land within six cycles
   task automatic send(input logic [7:0] c, input int n,
      input logic [39:0] p);
      put(1'b0, 1'b0, c);
      for (int i = 0; i < n; i++) begin
         put(1'b1, 1'b0, p[8*i+:8]);
      end
      repeat (6) @(posedge clk_sys_in);
   endtask : send
   task automatic win(input int c0, input int c1, input int r0, input int r1);
      send(DRAS_CMD_COL, 2, {24'h0, 8'(c1), 8'(c0)});
      send(DRAS_CMD_ROW, 2, {24'h0, 8'(r1), 8'(r0)});
      cs = c0;
      ce = c1;
      rs = r0;
      re = r1;
      cp = c0;
      rp = r0;
   endtask : win
   function automatic void adv();
      if (!vert) begin
         if (cp == ce) begin
            cp = cs;
            rp = (rp == re) ? rs : rp + 1;
         end else cp++;
      end else begin
         if (rp == re) begin
            rp = rs;
            cp = (cp == ce) ? cs : cp + 1;
         end else rp++;
      end
   endfunction : adv
   task automatic sess(input bit wr, input int n, input logic [7:0] base);
      int t;
      put(1'b0, 1'b0, wr ? DRAS_CMD_WRITE : DRAS_CMD_READ);
      for (int i = 0; i < n; i++) begin
         if (wr) mem[rp*256+cp] = base + 8'(i);
         else expq.push_back(mem[rp*256+cp]);
         put(1'b1, !wr, wr ? base + 8'(i) : 8'h00);
         adv();
      end
      t = 0;
      while (!wr && ansq.size() < n && t < 200) begin
         @(posedge clk_sys_in);
         t++;
      end
      chkn(ansq.size(), wr ? 0 : n);
      while (!wr && ansq.size() > 0 && expq.size() > 0) begin
         chk8(ansq.pop_front(), expq.pop_front());
      end
   endtask : sess
   task automatic wait_step(output int cyc);
      logic [7:0] v;
      @(negedge clk_sys_in);
      v = vscroll_pos_out;
      // The step edge lies one cycle before this first sample
      cyc = 1;
      do begin
         @(negedge clk_sys_in);
         cyc++;
      end while (vscroll_pos_out === v && cyc < 7000);
      @(posedge clk_sys_in);
   endtask : wait_step
   initial begin
      #300us;
      fails++;
      report_and_stop();
   end
   initial begin
      repeat (6) @(posedge clk_sys_in);
      resetn_in <= 1'b1;
      @(posedge clk_sys_in);
      chkn({contrast_a_out, contrast_b_out, contrast_c_out}, 24'h808080);
      chk8({4'h0, master_scale_out}, 8'h0F);
      chkn({vfix_rows_out, vscroll_rows_out}, 16'h0084);
      chk8({scroll_active_out, reverse_copy_out, color_fmt_out,
         common_split_out, common_scan_rev_out, common_lr_swap_out,
         col_mirror_out}, 8'h00);
      send(8'h81, 1, 40'h00);
      send(8'h82, 1, 40'hFF);
      send(8'h83, 1, 40'h5A);
      chk8(contrast_a_out, 8'h00);
      chk8(contrast_b_out, 8'hFF);
      chk8(contrast_c_out, 8'h5A);
      send(DRAS_CMD_MASTER, 1, 40'h00);
      chk8({4'h0, master_scale_out}, 8'h00);
      send(DRAS_CMD_MASTER, 1, 40'h07);
      chk8({4'h0, master_scale_out}, 8'h07);
      send(DRAS_CMD_FILLOPT, 1, 40'h10);
      chk8({7'h0, reverse_copy_out}, 8'h01);
      send(DRAS_CMD_FILLOPT, 1, 40'h00);
      chk8({7'h0, reverse_copy_out}, 8'h00);
      foreach (hoffs[k]) begin
         send(DRAS_CMD_REMAP, 1, {32'h0, 8'hAA ^ 8'(k * 8'hFE)});
         chk8({1'b0, color_fmt_out, common_split_out, common_scan_rev_out,
            common_lr_swap_out, rgb_swap_out, col_mirror_out},
            (8'hAA ^ 8'(k * 8'hFE)) >> 1);
      end
      send(DRAS_CMD_VAREA, 2, 40'h05_02);
      chk8(vfix_rows_out, 8'h02);
      chk8(vscroll_rows_out, 8'h05);
      foreach (frames[k]) begin
         send(DRAS_CMD_SCROLL, 5, {6'h0, 2'(k), 8'h03, 8'h84, 8'h00,
            8'(hoffs[k])});
         send(DRAS_CMD_START, 0, 40'h0);
         chk8({7'h0, scroll_active_out}, 8'h01);
         wait_step(gap);
         h0 = hscroll_pos_out;
         v0 = vscroll_pos_out;
         wait_step(gap);
         chkn(gap, frames[k] * 64);
         chk8(hscroll_pos_out, 8'((h0 + hoffs[k]) % 160));
         chk8(vscroll_pos_out, 8'((v0 + 3) % 5));
         send(DRAS_CMD_STOP, 0, 40'h0);
         chk8({7'h0, scroll_active_out}, 8'h00);
      end
      send(DRAS_CMD_REMAP, 1, 40'h00);
      win(2, 4, 1, 2);
      sess(1'b1, 8, 8'h10);
      win(2, 4, 1, 2);
      sess(1'b0, 6, 8'h00);
      send(DRAS_CMD_REMAP, 1, 40'h01);
      vert = 1'b1;
      win(10, 11, 20, 22);
      sess(1'b1, 7, 8'h40);
      win(10, 11, 20, 22);
      sess(1'b0, 6, 8'h00);
      report_and_stop();
   end
endmodule : display_ram_addressing_scroll_tb
`default_nettype wire
